// file: hw/startup_reset_sequencer.v
// Startup reset sequencer: reset merge, power-on timer, startup sequence
// Function
// - Either reset source holds chip in reset
// - Release when both sources are inactive
// - Power-on reset holds 3 ms, may 1.5
// - Start from external reset or power-up
// - Clock request asserts 120 us after release
// - Sleep at least 4.2 ms after release
// - No compensated oscillator means crystal reference
// - No slow clock seen: use internal one
`timescale 1ns/100ps
`include "startup_seq_defines.vh"
module startup_reset_sequencer #(
  parameter POR_CYCLES    = `POR_TYP_CYC,
  parameter SLEEP_CYCLES  = `SLEEP_MIN_CYC,
  parameter CLKREQ_CYCLES = `CLKREQ_CYC,
  parameter SLOW_WIN      = `SLOW_WIN_CYC,
  parameter HAS_CLKREQ    = 1
) (
  input  wire ref_clk,
  input  wire rst,
  input  wire ext_reset_n,
  input  wire core_supply_ok,
  input  wire compensated_oscillator,
  input  wire slow_clock_input,
  input  wire internal_slow_clock,
  output reg  chip_reset_n,
  output reg  clock_request,
  output reg  sleep_active,
  output reg  startup_done,
  output reg  use_crystal,
  output reg  use_internal_slow,
  output reg  slow_sleep_clock,
  output reg  por_active
);
  localparam ST_RESET  = `ST_RESET;
  localparam ST_SLEEP  = `ST_SLEEP;
  localparam ST_DETECT = `ST_DETECT;
  localparam ST_RUN    = `ST_RUN;

  wire        ext_rst_n_s;     // Synchronised external reset
  wire        supply_ok_s;     // Synchronised supply threshold flag
  wire        osc_fit_s;       // Synchronised oscillator presence
  wire        slow_s;          // Synchronised slow clock input
  wire        int_slow_s;      // Synchronised internal slow clock
  reg  [23:0] por_cnt_q;       // Power-on reset timer
  reg  [1:0]  rel_q;           // Reset release pipeline
  reg  [2:0]  state_q;         // Sequencer state
  reg  [23:0] seq_cnt_q;       // Time since release, held once sleep ends
  reg  [23:0] win_cnt_q;       // Slow clock detect window
  reg         slow_prev_q;     // Previous synchronised slow clock
  reg         slow_seen_q;     // Edge seen in the window
  wire        merged_n;        // Combined reset, active low

  sync3 #(.RESET_VAL(1'b0)) u_ext (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (ext_reset_n),
    .dout    (ext_rst_n_s)
  );
  sync3 #(.RESET_VAL(1'b0)) u_sup (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (core_supply_ok),
    .dout    (supply_ok_s)
  );
  sync3 #(.RESET_VAL(1'b0)) u_osc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (compensated_oscillator),
    .dout    (osc_fit_s)
  );
  sync3 #(.RESET_VAL(1'b0)) u_slow (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (slow_clock_input),
    .dout    (slow_s)
  );
  // The internal oscillator runs free of the reference clock, so it is
  // brought in through the same three stages as any outside pin
  sync3 #(.RESET_VAL(1'b0)) u_int_slow (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (internal_slow_clock),
    .dout    (int_slow_s)
  );

  // Power-on reset: counts from supply threshold; restarts on supply drop
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      por_cnt_q  <= 24'h00_0000;
      por_active <= 1'b1;
    end else if (!supply_ok_s) begin
      por_cnt_q  <= 24'h00_0000;
      por_active <= 1'b1;
    end else if (por_cnt_q < POR_CYCLES[23:0] - 24'h00_0001) begin
      por_cnt_q  <= por_cnt_q + 24'h00_0001;
      por_active <= 1'b1;
    end else begin
      por_active <= 1'b0;
    end
  end

  // Both sources must be inactive before any release can start
  assign merged_n = ext_rst_n_s & ~por_active;

  // Assert on the next edge, release through three flops on the reference clock
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rel_q        <= 2'b00;
      chip_reset_n <= 1'b0;
    end else if (!merged_n) begin
      rel_q        <= 2'b00;
      chip_reset_n <= 1'b0;
    end else begin
      rel_q        <= {rel_q[0], 1'b1};
      chip_reset_n <= rel_q[1];
    end
  end

  // Startup sequence, same path for both startup cases
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q           <= ST_RESET;
      seq_cnt_q         <= 24'h00_0000;
      win_cnt_q         <= 24'h00_0000;
      slow_prev_q       <= 1'b0;
      slow_seen_q       <= 1'b0;
      clock_request     <= 1'b0;
      sleep_active      <= 1'b0;
      startup_done      <= 1'b0;
      use_crystal       <= 1'b0;
      use_internal_slow <= 1'b0;
    end else if (!chip_reset_n) begin
      // Held off while either reset stands
      state_q       <= ST_RESET;
      seq_cnt_q     <= 24'h00_0000;
      win_cnt_q     <= 24'h00_0000;
      slow_seen_q   <= 1'b0;
      clock_request <= 1'b0;
      sleep_active  <= 1'b0;
      startup_done  <= 1'b0;
    end else begin
      slow_prev_q <= slow_s;
      // Clock request after its delay, only on parts that have it
      if (HAS_CLKREQ != 0 && seq_cnt_q >= CLKREQ_CYCLES[23:0]) begin
        clock_request <= 1'b1;
      end
      case (state_q)
        ST_RESET: begin
          state_q      <= ST_SLEEP;
          sleep_active <= 1'b1;
          seq_cnt_q    <= 24'h00_0001;
        end
        ST_SLEEP: begin
          seq_cnt_q <= seq_cnt_q + 24'h00_0001;
          // Board clocks are trusted only once sleep ends
          if (seq_cnt_q >= SLEEP_CYCLES[23:0]) begin
            state_q      <= ST_DETECT;
            sleep_active <= 1'b0;
            use_crystal  <= ~osc_fit_s;
            win_cnt_q    <= 24'h00_0000;
            slow_seen_q  <= 1'b0;
          end
        end
        ST_DETECT: begin
          // Look for any edge of the slow clock within the window
          if (slow_s != slow_prev_q) begin
            slow_seen_q <= 1'b1;
          end
          win_cnt_q <= win_cnt_q + 24'h00_0001;
          if (win_cnt_q >= SLOW_WIN[23:0]) begin
            state_q           <= ST_RUN;
            use_internal_slow <= ~slow_seen_q;
            startup_done      <= 1'b1;
          end
        end
        ST_RUN: begin
          // Sequence complete; stays here until the next reset
          startup_done <= 1'b1;
        end
        default: begin
          // Unused codes behave as the finished state
          startup_done <= 1'b1;
        end
      endcase
    end
  end

  // Slow clock mux; a glitch at switch-over is tolerated as it is once
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slow_sleep_clock <= 1'b0;
    end else if (use_internal_slow) begin
      slow_sleep_clock <= int_slow_s;
    end else begin
      slow_sleep_clock <= slow_s;
    end
  end
endmodule

// file: include/startup_seq_defines.vh
// Timing constants and state codes of the startup reset sequencer
`ifndef STARTUP_SEQ_DEFINES_VH
`define STARTUP_SEQ_DEFINES_VH
// Reference clock rate in kHz (100 MHz)
`define CLK_KHZ            100000
// Power-on reset hold, typical and earliest release, in microseconds
`define POR_TYP_US         3000
`define POR_MIN_US         1500
// Clock request delay after reset release, microseconds
`define CLKREQ_US          120
// Least sleep interval after reset release, microseconds
`define SLEEP_MIN_US       4200
// Slow clock activity window in microseconds
`define SLOW_WIN_US        100
// Cycle counts derived from the times above
`define POR_TYP_CYC        ((`POR_TYP_US * `CLK_KHZ) / 1000)
`define POR_MIN_CYC        ((`POR_MIN_US * `CLK_KHZ) / 1000)
`define CLKREQ_CYC         ((`CLKREQ_US * `CLK_KHZ) / 1000)
`define SLEEP_MIN_CYC      ((`SLEEP_MIN_US * `CLK_KHZ) / 1000)
`define SLOW_WIN_CYC       ((`SLOW_WIN_US * `CLK_KHZ) / 1000)
// Sequencer state codes
`define ST_RESET           3'h0
`define ST_SLEEP           3'h1
`define ST_DETECT          3'h2
`define ST_RUN             3'h3
`endif

// file: hw/sync3.v
// Three-stage synchroniser with second/third stage agreement
`timescale 1ns/100ps
module sync3 #(
  parameter RESET_VAL = 1'b0
) (
  input  wire ref_clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1_q;  // First stage, read only by the second
  reg s2_q;  // Second stage
  reg s3_q;  // Third stage

  // Output changes only when stages two and three agree
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// file: bench/seq_checker_sva.sv
// Checker of the startup reset sequencer outputs
`timescale 1ns/100ps
module seq_checker #(
  parameter POR_CYCLES    = 50,
  parameter SLEEP_CYCLES  = 100,
  parameter CLKREQ_CYCLES = 10,
  parameter SLOW_WIN      = 20
) (
  input wire ref_clk,
  input wire rst,
  input wire ext_reset_n,
  input wire core_supply_ok,
  input wire compensated_oscillator,
  input wire chip_reset_n,
  input wire clock_request,
  input wire sleep_active,
  input wire startup_done,
  input wire use_crystal,
  input wire por_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Cycles since chip release and since supply came up
  // Wide enough for the full-length counts of the design
  logic [23:0] rel_q, sup_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rel_q <= 24'h00_0000;
      sup_q <= 24'h00_0000;
    end else begin
      rel_q <= chip_reset_n ? rel_q + 24'h00_0001 : 24'h00_0000;
      sup_q <= core_supply_ok ? sup_q + 24'h00_0001 : 24'h00_0000;
    end
  end
  // The chip reset flop is low in the cycle after each cycle with the power-on flag set
  a_por_holds: assert property (por_active |=> !chip_reset_n)
    else $error("chip released during power-on reset");
  a_ext_holds: assert property (!ext_reset_n [*8] |-> !chip_reset_n)
    else $error("chip released during external reset");
  a_release_both: assert property ($rose(chip_reset_n) |->
    ext_reset_n && !por_active) else $error("early release");
  a_release_sync: assert property ($rose(chip_reset_n) |->
    $past(ext_reset_n, 3) && !$past(por_active, 3))
    else $error("release not delayed by synchroniser");
  a_por_time: assert property ($fell(por_active) |->
    sup_q >= POR_CYCLES && sup_q <= POR_CYCLES + 8) else $error("por time");
  a_sleep_start: assert property ($rose(chip_reset_n) |=> sleep_active)
    else $error("sleep not entered");
  a_sleep_min: assert property ($fell(sleep_active) && chip_reset_n |->
    rel_q >= SLEEP_CYCLES - 1) else $error("sleep too short");
  a_clkreq_time: assert property ($rose(clock_request) |->
    rel_q >= CLKREQ_CYCLES - 1 && rel_q <= CLKREQ_CYCLES + 2)
    else $error("clock request time");
  a_crystal_sel: assert property ($fell(sleep_active) && chip_reset_n |->
    use_crystal == !compensated_oscillator) else $error("crystal select");
  // Done clears one cycle after the chip reset flop falls
  a_done_order: assert property (startup_done |->
    $past(chip_reset_n) && !sleep_active) else $error("done out of order");
  a_done_time: assert property ($rose(startup_done) |->
    rel_q >= SLEEP_CYCLES + SLOW_WIN - 1) else $error("detect too short");
endmodule
bind startup_reset_sequencer seq_checker #(.POR_CYCLES(POR_CYCLES),
  .SLEEP_CYCLES(SLEEP_CYCLES), .CLKREQ_CYCLES(CLKREQ_CYCLES),
  .SLOW_WIN(SLOW_WIN)) seq_checker_i (.ref_clk(ref_clk), .rst(rst),
  .ext_reset_n(ext_reset_n), .core_supply_ok(core_supply_ok),
  .compensated_oscillator(compensated_oscillator),
  .chip_reset_n(chip_reset_n), .clock_request(clock_request),
  .sleep_active(sleep_active), .startup_done(startup_done),
  .use_crystal(use_crystal), .por_active(por_active));

// file: bench/board_model.sv
// Board model: external slow clock source and internal slow oscillator
`timescale 1ns/100ps
module board_model (
  input  wire  ref_clk,
  input  wire  slow_en,
  output logic slow_clock_input = 1'h0,
  output logic internal_slow_clock = 1'h0
);
  logic [3:0] div_q = 4'h0;
  // External clock stands still when not fitted, never floats
  always @(posedge ref_clk) begin
    div_q <= div_q + 4'h1;
    internal_slow_clock <= div_q[3];
    if (slow_en) slow_clock_input <= div_q[1];
  end
endmodule

// file: bench/startup_reset_sequencer_tb_top.sv
// Self-checking bench of the startup reset sequencer
`timescale 1ns/100ps
module startup_reset_sequencer_tb_top;
  logic ref_clk = 0, rst = 1, ext_reset_n = 1, supply = 0, comp = 0;
  logic slow_en = 1;
  wire  slow_in, int_slow, chip_reset_n, clock_request, sleep_active;
  wire  startup_done, use_crystal, use_internal_slow, por_active;
  wire  slow_clk;
  int   error_cnt = 0, checked = 0, cyc = 0;
  int   slow_edges = 0;
  // Short counts keep the run brief
  startup_reset_sequencer #(.POR_CYCLES(50), .SLEEP_CYCLES(100),
    .CLKREQ_CYCLES(10), .SLOW_WIN(20)) startup_reset_sequencer_i (
    .ref_clk(ref_clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .core_supply_ok(supply), .compensated_oscillator(comp),
    .slow_clock_input(slow_in), .internal_slow_clock(int_slow),
    .chip_reset_n(chip_reset_n), .clock_request(clock_request),
    .sleep_active(sleep_active), .startup_done(startup_done),
    .use_crystal(use_crystal), .use_internal_slow(use_internal_slow),
    .slow_sleep_clock(slow_clk), .por_active(por_active));
  board_model board_model_i (.ref_clk(ref_clk), .slow_en(slow_en),
    .slow_clock_input(slow_in), .internal_slow_clock(int_slow));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs change one step after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 400 && startup_done !== 1'h1; i++) tick(1);
    chk(startup_done, 1'h1);
  endtask
  // Changes of the selected slow clock over 64 cycles
  task automatic count_slow(output int n);
    logic last;
    n = 0;
    last = slow_clk;
    repeat (64) begin
      tick(1);
      if (slow_clk !== last) n++;
      last = slow_clk;
    end
  endtask
  task automatic por_start;
    supply = 1;
    tick(40);
    chk(chip_reset_n, 1'h0);
    tick(30);
    chk(por_active, 1'h0);
    wait_done;
    chk(clock_request, 1'h1);
    chk(use_crystal, 1'h1);
    chk(use_internal_slow, 1'h0);
    // Board clock toggles every 2 cycles, so many changes are expected
    count_slow(slow_edges);
    chk(slow_edges >= 24, 1'h1);
  endtask
  task automatic ext_hold;
    comp = 1;
    slow_en = 0;
    ext_reset_n = 0;
    tick(200);
    chk(sleep_active, 1'h0);
    ext_reset_n = 1;
    tick(90);
    chk(sleep_active, 1'h1);
    wait_done;
    chk(use_crystal, 1'h0);
    chk(use_internal_slow, 1'h1);
    // Internal clock toggles every 8 cycles; board clock stands still
    count_slow(slow_edges);
    chk(slow_edges >= 6 && slow_edges <= 10, 1'h1);
  endtask
  // Supply dip restarts the power-on timer
  task automatic supply_drop;
    supply = 0;
    comp = 0;
    slow_en = 1;
    tick(8);
    chk(por_active, 1'h1);
    supply = 1;
    tick(40);
    chk(chip_reset_n, 1'h0);
    wait_done;
    chk(use_internal_slow, 1'h0);
  endtask
  initial begin
    tick(3);
    rst = 0;
    por_start;
    ext_hold;
    supply_drop;
    results;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results;
    end
  end
endmodule
